// ---- hdl/dsoc_pkg.sv ----
// Purpose: Shared constants and carrier types for the deserializer output control
// Assumes: One recovered word-rate clock drives all logic
// Notes: Output enables are active low (low means the pin is driven)
package dsoc_pkg;
    localparam int DSOC_DATA_W = 32;                          // Parallel word width
    localparam logic [31:0] DSOC_DATA_RST = 32'h0000_0000;    // Data value after reset
    localparam logic DSOC_OE_OFF = 1'b1;                      // Enable level for a floating pin
    localparam logic DSOC_OE_ON = 1'b0;                       // Enable level for a driven pin

    // Recovered word with its launch-edge choice
    typedef struct packed {
        logic [31:0] data;
        logic edge_rise;
    } dsoc_word_t;

    // Output pin group: values and active-low enables
    typedef struct packed {
        logic [31:0] data;
        logic data_oe_n;
        logic clk;
        logic clk_oe_n;
        logic lock;
        logic lock_oe_n;
    } dsoc_pins_t;

    // Output gating states
    typedef enum logic [1:0] {
        DSOC_STANDBY,
        DSOC_UNLOCKED,
        DSOC_DISABLED,
        DSOC_ACTIVE
    } dsoc_state_t;
endpackage

// ---- hdl/dsoc_output_ctrl.sv ----
// Purpose: Gates recovered parallel data, recovered clock and lock onto output pins
// Assumes: ref_clk_i is the word-rate clock recovered from the serial lanes
// Notes: Standby also acts as a synchronous hold-off of the recovery loop
`timescale 1ns/10ps

// Function
// (RULE1) Unlocked: lock low, data and clock float
// (RULE2) Drive lock high once recovery has locked
// (RULE3) Output word-rate clock from recovered clock
// (RULE4) Edge select high: launch data on rising
// (RULE5) Edge select low: launch data on falling
// (RULE6) Output enable low floats data, clock
// (RULE7) Standby floats everything, stops recovery loop
// (RULE8) Drive data, clock only when fully ready
module dsoc_output_ctrl
    import dsoc_pkg::*;
#(
    parameter int DATA_W = DSOC_DATA_W
) (
    input wire logic ref_clk_i,                     // Recovered word-rate clock
    input wire logic rst_n_i,                       // Asynchronous active-low reset
    input wire logic [DATA_W-1:0] recovered_word_i, // Word from the decode path
    input wire logic cdr_locked_i,                  // Recovery loop reports lock
    input wire logic output_enable_i,               // Active-high output enable
    input wire logic standby_request_n_i,           // Active-low power-down
    input wire logic output_edge_select_i,          // High rising, low falling
    output logic recovery_run_o,                    // Keeps recovery loop running
    output logic [DATA_W-1:0] recovered_parallel_data_o,
    output logic recovered_parallel_data_oe_n_o,
    output logic recovered_clock_out_o,
    output logic recovered_clock_out_oe_n_o,
    output logic lock_o,
    output logic lock_oe_n_o
);

    dsoc_state_t state_reg, state_next;               // Gating state
    logic [DATA_W-1:0] rise_data_reg, rise_data_next; // Word launched at rising edge
    logic [DATA_W-1:0] fall_data_reg, fall_data_next; // Word relaunched at falling edge
    logic run_reg, run_next;                          // Recovery loop run flag
    logic lock_reg, lock_next;                        // Registered lock pin value
    logic data_oe_n_reg, data_oe_n_next;              // Data pin enable
    logic clk_oe_n_reg, clk_oe_n_next;                // Clock pin enable
    logic lock_oe_n_reg, lock_oe_n_next;              // Lock pin enable
    logic edge_rise_reg, edge_rise_next;              // Captured edge choice
    logic clk_gate_reg, clk_gate_next;                // Clock pin gate, low edge safe

    // State selection from power, lock and enable
    always_comb begin
        state_next = state_reg;
        if (!standby_request_n_i) begin
            // Power-down outranks lock and enable
            state_next = DSOC_STANDBY;                // [RULE7]
        end else if (!cdr_locked_i) begin
            // No lock: nothing but the lock pin is driven
            state_next = DSOC_UNLOCKED;               // [RULE1]
        end else if (!output_enable_i) begin
            // Locked but held off by the enable input
            state_next = DSOC_DISABLED;               // [RULE6]
        end else begin
            // Powered, locked and enabled
            state_next = DSOC_ACTIVE;                 // [RULE8]
        end
    end

    // Pin enables and lock value for the next state
    always_comb begin
        // Defaults: loop runs unless in standby, lock driven low, data and clock floating
        run_next = standby_request_n_i;               // [RULE7]
        lock_next = 1'b0;
        lock_oe_n_next = DSOC_OE_ON;
        data_oe_n_next = DSOC_OE_OFF;
        clk_oe_n_next = DSOC_OE_OFF;
        unique case (state_next)
            DSOC_STANDBY: begin
                // Lock pin released as well
                lock_oe_n_next = DSOC_OE_OFF;         // [RULE7]
            end
            DSOC_UNLOCKED: begin
                // Lock reported low on a driven pin
                lock_next = 1'b0;                     // [RULE1]
            end
            DSOC_DISABLED: begin
                // Lock still reported; data and clock stay floating
                lock_next = 1'b1;                     // [RULE2] [RULE6]
            end
            DSOC_ACTIVE: begin
                // Only state that drives data and clock
                lock_next = 1'b1;                     // [RULE2]
                data_oe_n_next = DSOC_OE_ON;          // [RULE8]
                clk_oe_n_next = DSOC_OE_ON;
            end
        endcase
        // Data and edge choice are taken every cycle, even while floating
        rise_data_next = recovered_word_i;
        edge_rise_next = output_edge_select_i;
    end

    // Rising-edge registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Reset: every pin floats and the loop is held off
            state_reg <= DSOC_STANDBY;
            run_reg <= 1'b0;
            lock_reg <= 1'b0;
            lock_oe_n_reg <= DSOC_OE_OFF;
            data_oe_n_reg <= DSOC_OE_OFF;
            clk_oe_n_reg <= DSOC_OE_OFF;
            rise_data_reg <= DSOC_DATA_RST[DATA_W-1:0];
            edge_rise_reg <= 1'b1;
        end else begin
            // Take the next values
            state_reg <= state_next;
            run_reg <= run_next;
            lock_reg <= lock_next;
            lock_oe_n_reg <= lock_oe_n_next;
            data_oe_n_reg <= data_oe_n_next;
            clk_oe_n_reg <= clk_oe_n_next;
            rise_data_reg <= rise_data_next;          // [RULE4]
            edge_rise_reg <= edge_rise_next;
        end
    end

    // Falling-edge next values: data copy and clock gate
    // The gate changes only while the clock is low, so the clock pin never shows a runt pulse
    always_comb begin
        fall_data_next = rise_data_reg;               // [RULE5]
        clk_gate_next = (clk_oe_n_reg == DSOC_OE_ON); // [RULE3]
    end

    // Falling-edge copy moves data changes to the falling edge
    always_ff @(negedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Reset: gate closed, copy cleared
            fall_data_reg <= DSOC_DATA_RST[DATA_W-1:0];
            clk_gate_reg <= 1'b0;
        end else begin
            fall_data_reg <= fall_data_next;          // [RULE5]
            clk_gate_reg <= clk_gate_next;
        end
    end

    // Pin drive; the clock pin follows the recovered clock while gated on
    always_comb begin
        recovery_run_o = run_reg;
        lock_o = lock_reg;                            // [RULE2]
        lock_oe_n_o = lock_oe_n_reg;
        recovered_parallel_data_oe_n_o = data_oe_n_reg;
        recovered_clock_out_oe_n_o = clk_oe_n_reg;
        // Clock pin is the recovered clock masked by the gate; low while gated off
        recovered_clock_out_o = ref_clk_i & clk_gate_reg; // [RULE3]
        // Registered select picks which copy of the word the pins show
        if (edge_rise_reg) begin
            recovered_parallel_data_o = rise_data_reg;    // [RULE4]
        end else begin
            recovered_parallel_data_o = fall_data_reg;    // [RULE5]
        end
    end

    // Checks
    // Unlocked: lock reported low, data and clock released
    a_unlock_floats: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE1]
        (standby_request_n_i && !cdr_locked_i) |=> (!lock_o && data_oe_n_reg && clk_oe_n_reg))
        else $error("unlocked output not floated");

    // Lock pin stays driven whenever the block is powered
    a_lock_driven: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE1]
        standby_request_n_i |=> !lock_oe_n_o)
        else $error("lock pin not driven");

    // Lock reported high on a driven pin once locked
    a_lock_high: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE2]
        (standby_request_n_i && cdr_locked_i) |=> lock_o && !lock_oe_n_o)
        else $error("lock not reported");

    // Clock gate closes once the clock pin is released
    a_clock_gated: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE3]
        clk_oe_n_reg |-> ##1 (!clk_gate_reg || !clk_oe_n_reg))
        else $error("clock gate stale");

    // Open gate: clock pin is high in the high phase
    a_clock_follows: assert property (@(negedge ref_clk_i) disable iff (!rst_n_i) // [RULE3]
        clk_gate_reg |-> recovered_clock_out_o)
        else $error("clock pin not toggling");

    // Released clock pin stays low
    a_clock_quiet: assert property (@(negedge ref_clk_i) disable iff (!rst_n_i) // [RULE6]
        clk_oe_n_reg ##1 clk_oe_n_reg |-> !recovered_clock_out_o)
        else $error("released clock pin toggling");

    // Rising mode: pins show the word taken at the last rising edge
    a_rise_launch: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE4]
        (edge_rise_reg && $past(rst_n_i)) |-> recovered_parallel_data_o == $past(recovered_word_i))
        else $error("rising launch wrong");

    // Falling mode: pins change only at the falling edge
    a_fall_launch: assert property (@(negedge ref_clk_i) disable iff (!rst_n_i) // [RULE5]
        !edge_rise_reg ##1 !edge_rise_reg |-> recovered_parallel_data_o == $past(rise_data_reg))
        else $error("falling launch wrong");

    // Disabled: data and clock released, loop kept running
    a_disable_floats: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE6]
        (standby_request_n_i && !output_enable_i) |=> data_oe_n_reg && clk_oe_n_reg && run_reg)
        else $error("disabled output driven");

    // Standby: every pin released and the loop stopped
    a_standby_all: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE7]
        !standby_request_n_i |=> lock_oe_n_o && data_oe_n_reg && clk_oe_n_reg && !recovery_run_o)
        else $error("standby not honoured");

    // Data pins driven only after power, lock and enable were all seen
    a_drive_ready: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE8]
        !data_oe_n_reg |-> $past(standby_request_n_i && cdr_locked_i && output_enable_i))
        else $error("driven when not ready");

    // Main scenarios
    // Fully driven output
    c_active: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) state_reg == DSOC_ACTIVE);
    // Enable dropped while running
    c_disabled: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_reg == DSOC_ACTIVE ##1 state_reg == DSOC_DISABLED);
    // Lock lost while running
    c_lock_loss: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_reg == DSOC_ACTIVE ##1 state_reg == DSOC_UNLOCKED);
    // Falling-edge launch while driving
    c_fall_mode: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !edge_rise_reg && state_reg == DSOC_ACTIVE);

endmodule

// ---- dv/dsoc_serializer_model.sv ----
// Purpose: Far-side serializer stand-in feeding the recovered word and lock
// Assumes: Lock is acquired LOCK_CYC+1 cycles after the recovery loop is let run
// Notes: The word changes every cycle so that a stale output is always seen
`timescale 1ns/10ps
module dsoc_serializer_model #(
    parameter int LOCK_CYC = 4
) (
    input wire logic ref_clk_i,          // Word-rate clock
    input wire logic rst_n_i,            // Asynchronous active-low reset
    input wire logic recovery_run_i,     // Loop running, from the block
    input wire logic drop_lock_i,        // Forces a loss of lock
    output logic [31:0] recovered_word_o,
    output logic cdr_locked_o
);
    int cnt; // Cycles since the loop started
    // Word stream and lock acquisition
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            recovered_word_o <= 32'h1234_5678;
            cdr_locked_o <= 1'b0;
            cnt <= 0;
        end else begin
            recovered_word_o <= recovered_word_o + 32'h9E37_79B9;
            if (!recovery_run_i || drop_lock_i) begin
                cnt <= 0; // A stopped loop loses lock
                cdr_locked_o <= 1'b0;
            end else if (cnt < LOCK_CYC) begin
                cnt <= cnt + 1;
            end else begin
                cdr_locked_o <= 1'b1;
            end
        end
    end
endmodule

// ---- dv/dsoc_output_ctrl_tb.sv ----
// Purpose: Self-checking bench for the output gating and launch-edge logic
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Expected data is captured from the word stream before each edge
`timescale 1ns/10ps
module dsoc_output_ctrl_tb;
    import dsoc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, sby_n = 1'b0, sel = 1'b1, drop = 1'b0;
    logic run, lock_v, loe, doe, cko, coe, lk;
    logic [31:0] word, dat, w, prev;
    int error_cnt = 0, n_checks = 0;
    initial forever #5 clk = ~clk;
    dsoc_serializer_model dsoc_serializer_model_inst (.ref_clk_i(clk), .rst_n_i(rst_n),
        .recovery_run_i(run), .drop_lock_i(drop), .recovered_word_o(word), .cdr_locked_o(lk));
    dsoc_output_ctrl dsoc_output_ctrl_inst (.ref_clk_i(clk), .rst_n_i(rst_n), .recovered_word_i(word),
        .cdr_locked_i(lk), .output_enable_i(en), .standby_request_n_i(sby_n),
        .output_edge_select_i(sel), .recovery_run_o(run), .recovered_parallel_data_o(dat),
        .recovered_parallel_data_oe_n_o(doe), .recovered_clock_out_o(cko),
        .recovered_clock_out_oe_n_o(coe), .lock_o(lock_v), .lock_oe_n_o(loe));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Report and stop
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Data launch on the chosen edge, four words; starts and ends 1 ns after a rising edge
    task automatic edge_run(input logic s);
        sel = s;
        w = word; // Word the next edge captures
        step(1); // Select is registered
        repeat (4) begin
            prev = w;
            w = word; // Word the next edge captures
            @(posedge clk);
            #2 chk(dat, s ? w : prev);
            @(negedge clk);
            #1 chk(dat, w);
        end
        step(1);
    endtask
    // Bounded wait for lock; a miss is counted and closes the run
    task automatic wait_lock();
        for (int i = 0; i < 20 && lock_v !== 1'b1; i++) step(1);
        chk(lock_v, 1'b1);
        if (lock_v !== 1'b1) give_verdict();
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        step(2);
        chk(loe, DSOC_OE_OFF);
        chk(doe, DSOC_OE_OFF);
        chk(run, 1'b0);
        sby_n = 1'b1;
        step(2);
        chk({lock_v, loe}, {1'b0, DSOC_OE_ON});
        chk({doe, coe}, {DSOC_OE_OFF, DSOC_OE_OFF});
        wait_lock();
        chk({loe, doe, coe}, {3{DSOC_OE_ON}});
        @(negedge clk);
        #2 chk(cko, 1'b0);
        step(1);
        chk(cko, 1'b1);
        edge_run(1'b1);
        edge_run(1'b0);
        en = 1'b0;
        step(2);
        chk({doe, coe}, {DSOC_OE_OFF, DSOC_OE_OFF});
        chk({lock_v, run}, 2'b11);
        chk(cko, 1'b0);
        en = 1'b1;
        drop = 1'b1;
        step(3);
        chk({lock_v, doe, coe}, {1'b0, DSOC_OE_OFF, DSOC_OE_OFF});
        drop = 1'b0;
        wait_lock();
        sby_n = 1'b0;
        step(2);
        chk({lock_v, loe, doe, coe, run, cko}, {1'b0, DSOC_OE_OFF, DSOC_OE_OFF, DSOC_OE_OFF, 2'b00});
        give_verdict();
    end
endmodule
